// ==== design/serial_transparent_channel.v ====
// transparent serial channel with single transmit and receive descriptor
`timescale 1ns/1ps
`include "xparent_consts.vh"
module serial_transparent_channel (
  input wire clk_sys,
  input wire reset,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire serial_bit_clock,
  input wire sync_pin_n,
  input wire tdm_frame_sync,
  input wire tdm_tx_slot,
  input wire tdm_rx_slot,
  input wire rx_data,
  output reg tx_data,
  output reg tx_event,
  output reg rx_event
);

// ------------------------------------------------------------
// input synchronisers
// ------------------------------------------------------------
reg [1:0] clk_s1;
reg [1:0] clk_s2;
reg [1:0] sync_s;
reg [3:0] tdm_s1;
reg [3:0] tdm_s2;
reg clk_prev;
always @(posedge clk_sys) begin
  if (reset) begin
    clk_s1 <= 2'h0;
    clk_s2 <= 2'h0;
    sync_s <= 2'h3;
    tdm_s1 <= 4'h0;
    tdm_s2 <= 4'h0;
    clk_prev <= 1'b0;
  end else begin
    clk_s1 <= {rx_data, serial_bit_clock};
    clk_s2 <= clk_s1;
    sync_s <= {sync_s[0], sync_pin_n};
    tdm_s1 <= {tdm_rx_slot, tdm_tx_slot, tdm_frame_sync, 1'b0};
    tdm_s2 <= tdm_s1;
    clk_prev <= clk_s2[0];
  end
end
wire bclk = clk_s2[0];
wire rx_bit = clk_s2[1];
wire sync_low = ~sync_s[1];
wire frame_sync = tdm_s2[1];
wire tx_slot = tdm_s2[2];
wire rx_slot = tdm_s2[3];
// one bit clock shared by both directions
wire rise = bclk & ~clk_prev;
wire fall = ~bclk & clk_prev;

// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
reg [15:0] mode;
reg [4:0] tx_desc;
reg [15:0] tx_buf;
reg [4:0] rx_desc;
reg [15:0] rx_buf;
reg underrun;
reg tx_sync;
reg rx_sync;
reg tx_ev_flag;
reg rx_ev_flag;
wire tx_en = mode[`MODE_TX_EN];
wire rx_en = mode[`MODE_RX_EN];
wire tdm = mode[`MODE_TDM];
wire reverse = mode[`MODE_REVERSE];
// length code 3..15 means 4..16 bits
wire [3:0] len_code = (mode[7:4] < `MIN_LEN) ? `MIN_LEN : mode[7:4];

// ------------------------------------------------------------
// transmitter
// ------------------------------------------------------------
reg [3:0] tx_cnt;
reg [15:0] tx_sh;
reg tx_data_char;
reg tx_pre_done;
reg tx_frame_seen;
reg tx_load_ok;
// underrun only counts after a descriptor that was not the last
reg tx_last_closed;
wire tx_gate = tdm ? tx_slot : 1'b1;
wire tx_ready = tx_desc[`DESC_READY];
always @(posedge clk_sys) begin
  if (reset) begin
    tx_cnt <= 4'h0;
    tx_sh <= 16'hFFFF;
    tx_data_char <= 1'b0;
    tx_pre_done <= 1'b0;
    tx_sync <= 1'b0;
    tx_frame_seen <= 1'b0;
    tx_data <= 1'b1;
    tx_event <= 1'b0;
    tx_ev_flag <= 1'b0;
    underrun <= 1'b0;
    tx_load_ok <= 1'b0;
    tx_last_closed <= 1'b0;
  end else begin
    tx_event <= 1'b0;
    // clears sit first so a same-cycle set below wins
    if (wr && addr == `REG_STATUS && wdata[`ST_TX_EVENT])
      tx_ev_flag <= 1'b0;
    if (wr && addr == `REG_STATUS && wdata[`ST_UNDERRUN])
      underrun <= 1'b0;
    if (!tx_en) begin
      tx_sync <= 1'b0;
      tx_pre_done <= 1'b0;
      tx_frame_seen <= 1'b0;
      tx_data_char <= 1'b0;
      tx_cnt <= 4'h0;
      tx_data <= 1'b1;
      tx_load_ok <= 1'b0;
    end else begin
      if (frame_sync)
        tx_frame_seen <= 1'b1;
      // pin sync; first slot after frame sync with the tx descriptor ready
      if (!tx_sync && !tdm && rise && sync_low)
        tx_sync <= 1'b1;
      if (!tx_sync && tdm && tx_frame_seen && tx_slot && tx_ready)
        tx_sync <= 1'b1;
      if (fall && tx_gate) begin
        // idles until data; one bit per clock
        tx_data <= (tx_sync && tx_data_char) ? tx_sh[0] : 1'b1;
        tx_sh <= {1'b1, tx_sh[15:1]};
        if (tx_cnt == len_code) begin
          tx_cnt <= 4'h0;
          tx_data_char <= 1'b0;
          // two full ones characters before first data outside TDM; in TDM data loads at the first boundary
          if (tx_sync)
            tx_pre_done <= tdm ? 1'b1 : tx_load_ok;
          tx_load_ok <= tx_sync;
          if (tx_sync && (tx_pre_done || tdm) && tx_ready) begin
            tx_sh <= reverse ? rev16(tx_buf) >> (4'hF - len_code) : tx_buf;
            tx_data_char <= 1'b1;
            underrun <= 1'b0;
            tx_last_closed <= tx_desc[`DESC_LAST];
            if (tx_desc[`DESC_IRQ]) begin
              tx_event <= 1'b1;
              tx_ev_flag <= 1'b1;
            end
          end else if (tx_sync && tx_data_char && !tx_ready && !tx_last_closed) begin
            // ran out of buffers after a non-last one
            underrun <= 1'b1;
          end
        end else begin
          tx_cnt <= tx_cnt + 4'h1;
        end
      end
    end
  end
end

function [15:0] rev16;
  input [15:0] v;
  integer i;
  begin
    for (i = 0; i < 16; i = i + 1)
      rev16[i] = v[15 - i];
  end
endfunction

// tx descriptor closes at the load above
wire tx_close = fall && tx_gate && tx_cnt == len_code && tx_sync && (tx_pre_done || tdm) && tx_ready && tx_en;

// ------------------------------------------------------------
// receiver
// ------------------------------------------------------------
reg [3:0] rx_cnt;
reg [15:0] rx_sh;
reg rx_frame_seen;
reg rx_full;
wire rx_gate = tdm ? rx_slot : 1'b1;
wire rx_sync_now = !rx_sync && (tdm ? (rx_frame_seen && rx_slot) : sync_low);
wire rx_take = rx_en && rise && rx_gate && (rx_sync || rx_sync_now);
wire [15:0] rx_next_sh = reverse ? {rx_sh[14:0], rx_bit} : {rx_bit, rx_sh[15:1]};
wire rx_close = rx_take && rx_cnt == len_code;
always @(posedge clk_sys) begin
  if (reset) begin
    rx_cnt <= 4'h0;
    rx_sh <= 16'h0000;
    rx_sync <= 1'b0;
    rx_frame_seen <= 1'b0;
    rx_event <= 1'b0;
    rx_ev_flag <= 1'b0;
    rx_full <= 1'b0;
  end else begin
    rx_event <= 1'b0;
    if (wr && addr == `REG_STATUS && wdata[`ST_RX_EVENT])
      rx_ev_flag <= 1'b0;
    if (!rx_en) begin
      rx_sync <= 1'b0;
      rx_cnt <= 4'h0;
      rx_frame_seen <= 1'b0;
    end else begin
      if (frame_sync)
        rx_frame_seen <= 1'b1;
      // first sampled low syncs and latches bit
      if (rx_take) begin
        rx_sync <= 1'b1;
        rx_sh <= rx_next_sh;
        rx_cnt <= rx_close ? 4'h0 : rx_cnt + 4'h1;
      end
      // store only into an empty descriptor
      if (rx_close && rx_desc[`DESC_READY]) begin
        rx_full <= 1'b1;
        if (rx_desc[`DESC_IRQ]) begin
          rx_event <= 1'b1;
          rx_ev_flag <= 1'b1;
        end
      end
    end
  end
end

// ------------------------------------------------------------
// descriptors and register port
// ------------------------------------------------------------
always @(posedge clk_sys) begin
  if (reset) begin
    mode <= `MODE_RESET;
    tx_desc <= 5'h00;
    tx_buf <= 16'h0000;
    rx_desc <= 5'h00;
    rx_buf <= 16'h0000;
    rdata <= 16'h0000;
  end else begin
    if (wr && addr == `REG_MODE)
      mode <= wdata;
    if (wr && addr == `REG_TX_DATA)
      tx_buf <= wdata;
    if (wr && addr == `REG_TX_DESC)
      tx_desc <= wdata[4:0];
    // close clears ready; continuous keeps it
    else if (tx_close && !tx_desc[`DESC_CONT])
      tx_desc[`DESC_READY] <= 1'b0;
    if (wr && addr == `REG_RX_DESC)
      rx_desc <= wdata[4:0];
    // clear empty on fill; continuous keeps it
    else if (rx_en && rx_close && rx_desc[`DESC_READY] && !rx_desc[`DESC_CONT])
      rx_desc[`DESC_READY] <= 1'b0;
    if (rx_en && rx_close && rx_desc[`DESC_READY])
      rx_buf <= reverse ? rx_next_sh : rx_next_sh >> (4'hF - len_code);
    rdata <= 16'h0000;
    if (rd) begin
      case (addr)
        `REG_MODE: rdata <= mode;
        `REG_STATUS: rdata <= {8'h00, tx_cnt != 4'h0 || tx_data_char, rx_desc[`DESC_READY],
          tx_desc[`DESC_READY], rx_sync, tx_sync, underrun, rx_ev_flag, tx_ev_flag};
        `REG_TX_DESC: rdata <= {11'h000, tx_desc};
        `REG_TX_DATA: rdata <= tx_buf;
        `REG_RX_DESC: rdata <= {11'h000, rx_desc};
        `REG_RX_DATA: rdata <= rx_buf;
        default: rdata <= 16'h0000;
      endcase
    end
  end
end
endmodule // serial_transparent_channel

// ==== pkg/xparent_consts.vh ====
// constants for the transparent serial channel
`ifndef XPARENT_CONSTS_VH
`define XPARENT_CONSTS_VH
`define REG_MODE 8'h00
`define REG_STATUS 8'h04
`define REG_TX_DESC 8'h08
`define REG_TX_DATA 8'h0C
`define REG_RX_DESC 8'h10
`define REG_RX_DATA 8'h14
`define REG_RSVD_A 8'h28
`define REG_RSVD_B 8'h2A
`define REG_RSVD_C 8'h2C
`define REG_RSVD_D 8'h2E
`define REG_RSVD_E 8'h30
`define MODE_TX_EN 0
`define MODE_RX_EN 1
`define MODE_TDM 2
`define MODE_REVERSE 3
`define MODE_LEN_LSB 4
`define DESC_READY 0
`define DESC_LAST 1
`define DESC_IRQ 2
`define DESC_CONT 3
`define DESC_WRAP 4
`define ST_TX_EVENT 0
`define ST_RX_EVENT 1
`define ST_UNDERRUN 2
`define ST_TX_SYNC 3
`define ST_RX_SYNC 4
`define ST_TX_READY 5
`define ST_RX_EMPTY 6
`define ST_TX_BUSY 7
`define MIN_LEN 4'h3
`define MODE_RESET 16'h00F0
`endif

// ==== testbench/tb.sv ====
// self-checking bench for the transparent serial channel
`timescale 1ns/1ps
`include "xparent_consts.vh"
module tb;
  reg clk_sys = 1'b0;
  reg reset = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg go = 1'b0;
  reg [3:0] len = 4'h3;
  reg [15:0] word = 16'h0000;
  reg [15:0] tword = 16'h0000;
  reg [15:0] got;
  reg [15:0] mask;
  integer fails = 0;
  integer check_count = 0;
  integer tx_n = 0;
  integer rx_n = 0;
  integer n;
  integer k;
  wire [15:0] rdata;
  wire bclk, sync_n, rxd, tx_data, tx_event, rx_event;
  serial_transparent_channel dut (.clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .serial_bit_clock(bclk), .sync_pin_n(sync_n), .tdm_frame_sync(1'b0),
    .tdm_tx_slot(1'b0), .tdm_rx_slot(1'b0), .rx_data(rxd), .tx_data(tx_data), .tx_event(tx_event),
    .rx_event(rx_event));
  xparent_link_partner far (.go(go), .word(word), .len_code(len), .serial_bit_clock(bclk),
    .sync_pin_n(sync_n), .rx_data(rxd));
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (!reset) begin
      tx_n <= tx_n + tx_event;
      rx_n <= rx_n + rx_event;
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %0t got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
    end
  endtask
  task rd_chk(input [7:0] a, input [15:0] m, input [15:0] e);
    begin
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 check(rdata & m, e);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #400000;
    fails = fails + 1;
    stop_test;
  end
  initial begin
    k = $urandom(32'hBCFCED9F);
    len = 4'h3 + $urandom % 13;
    word = $urandom;
    tword = $urandom & 16'hFFFE;
    mask = (16'h0001 << (len + 5'd1)) - 16'h0001;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk(`REG_MODE, 16'hFFFF, `MODE_RESET);
    for (k = 8'h28; k <= 8'h40; k = k + 2) rd_chk(k[7:0], 16'hFFFF, 16'h0000);
    wr_reg(`REG_MODE, {8'h00, len, 4'h3});
    wr_reg(`REG_RX_DESC, 16'h0005);
    wr_reg(`REG_TX_DATA, tword & mask);
    wr_reg(`REG_TX_DESC, 16'h0007);
    n = 0;
    repeat (400) @(posedge clk_sys) n = n + !tx_data;
    check(n[15:0], 16'h0000);
    go <= 1'b1;
    n = 0;
    while (tx_data === 1'b1 && n < 200) begin
      @(posedge bclk);
      n = n + 1;
    end
    check({15'h0000, n > len}, 16'h0001);
    got = 16'h0000;
    for (k = 1; k <= len; k = k + 1) begin
      @(posedge bclk);
      got[k] = tx_data;
    end
    check(got, tword & mask);
    repeat (300) @(posedge clk_sys);
    check(tx_n[15:0], 16'h0001);
    check(rx_n[15:0], 16'h0001);
    rd_chk(`REG_TX_DESC, 16'h0001, 16'h0000);
    rd_chk(`REG_STATUS, 16'h0004, 16'h0000);
    rd_chk(`REG_RX_DESC, 16'h0001, 16'h0000);
    rd_chk(`REG_RX_DATA, mask, word & mask);
    wr_reg(`REG_TX_DESC, 16'h0019);
    repeat (600) @(posedge clk_sys);
    rd_chk(`REG_TX_DESC, 16'h0001, 16'h0001);
    wr_reg(`REG_TX_DESC, 16'h0000);
    repeat (600) @(posedge clk_sys);
    wr_reg(`REG_STATUS, 16'h0004);
    wr_reg(`REG_TX_DESC, 16'h0001);
    repeat (600) @(posedge clk_sys);
    rd_chk(`REG_TX_DESC, 16'h0001, 16'h0000);
    rd_chk(`REG_STATUS, 16'h0004, 16'h0004);
    check(tx_n[15:0], 16'h0001);
    stop_test;
  end
endmodule // tb

// ==== testbench/xparent_link_partner.sv ====
// far-side serial device: bit clock, sync pin, receive line
`timescale 1ns/1ps
module xparent_link_partner (
  input wire go,
  input wire [15:0] word,
  input wire [3:0] len_code,
  output reg serial_bit_clock,
  output reg sync_pin_n,
  output reg rx_data
);
  integer i;
  initial begin
    serial_bit_clock = 1'b0;
    sync_pin_n = 1'b1;
    rx_data = 1'b1;
    i = 0;
  end
  always #80 serial_bit_clock = ~serial_bit_clock;
  // single clean edge
  // undriven line toggles so no stale value passes
  always @(negedge serial_bit_clock) begin
    if (go) sync_pin_n <= 1'b0;
    rx_data <= (go && i <= len_code) ? word[i] : ~rx_data;
    if (go) i <= i + 1;
  end
endmodule // xparent_link_partner

// ==== testbench/xparent_monitor.sv ====
// port checker for the transparent serial channel
`timescale 1ns/1ps
module xparent_monitor (
  input wire clk_sys,
  input wire reset,
  input wire [7:0] addr,
  input wire rd,
  input wire [15:0] rdata,
  input wire serial_bit_clock,
  input wire sync_pin_n,
  input wire tdm_frame_sync,
  input wire tx_data,
  input wire tx_event,
  input wire rx_event
);
  reg [1:0] bc;
  reg [3:0] since_fall;
  reg synced;
  // bit clock seen through two flops, one fewer than the design, so falls show a cycle earlier
  always @(posedge clk_sys) begin
    bc <= {bc[0], serial_bit_clock};
    if (reset) begin
      since_fall <= 4'hF;
      synced <= 1'b0;
    end else begin
      since_fall <= (bc == 2'b10) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hF};
      synced <= synced | !sync_pin_n | tdm_frame_sync;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_rsvd_rd;
    rd && addr >= 8'h28 && addr <= 8'h30;
  endsequence
  property p_reset;
    disable iff (1'b0) reset |=> tx_data && !tx_event && !rx_event && rdata == 16'h0000;
  endproperty
  property p_rsvd; s_rsvd_rd |=> rdata == 16'h0000; endproperty
  property p_tx_pulse; tx_event |=> !tx_event; endproperty
  property p_rx_pulse; rx_event |=> !rx_event; endproperty
  property p_tx_edge; $changed(tx_data) |-> since_fall <= 4'h4; endproperty
  property p_tx_sync; !tx_data |-> synced; endproperty
  property p_rx_sync; rx_event |-> synced; endproperty
  property p_ones; $rose(synced) |-> tx_data [*8]; endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  a_rsvd: assert property (p_rsvd) else $error("reserved word not zero");
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx event too long");
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx event too long");
  a_tx_edge: assert property (p_tx_edge) else $error("tx bit off falling edge");
  a_tx_sync: assert property (p_tx_sync) else $error("data before sync");
  a_rx_sync: assert property (p_rx_sync) else $error("receive before sync");
  a_ones: assert property (p_ones) else $error("no ones after sync");
endmodule // xparent_monitor
bind serial_transparent_channel xparent_monitor mon (.clk_sys(clk_sys), .reset(reset), .addr(addr), .rd(rd),
  .rdata(rdata), .serial_bit_clock(serial_bit_clock), .sync_pin_n(sync_pin_n),
  .tdm_frame_sync(tdm_frame_sync), .tx_data(tx_data), .tx_event(tx_event), .rx_event(rx_event));
